// ==== hw/pll_consts.svh ====
/*
 Constants of the serial frequency synthesizer core: word layout, counter
 widths, latch reset values and prescaler moduli.
 Assumes it is included once per compilation unit by its bare name.
*/
`ifndef PLL_CONSTS_SVH
`define PLL_CONSTS_SVH

// ----------------------------------------
// Serial word layout
// ----------------------------------------
`define SHIFT_W 20
`define CTRL_BIT 19
`define REF_LAT_W 15
`define REF_LAT_LSB 4
`define REF_LAT_MSB 18
`define DIV_LAT_W 19
`define SEL_BIT 0
`define RATIO_MSB 14
`define RATIO_LSB 1
`define SWALLOW_MSB 7
`define MAIN_LSB 8
`define MAIN_MSB 18

// ----------------------------------------
// Counters
// ----------------------------------------
`define RATIO_W 14
`define SWALLOW_W 8
`define MAIN_W 11
`define PRE_W 9
`define PRE_LO_WIDE 9'h100
`define PRE_LO_NARROW 9'h080
`define REF_LAT_RST 15'h0010
`define DIV_LAT_RST 19'h0_1000
`define MAIN_ONE 11'h001

`endif

// ==== hw/pll_pkg.sv ====
/*
 Types shared by the synthesizer core.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pll_pkg;
   typedef enum logic [1:0] {
      PFD_IDLE = 2'b00,
      PFD_UP = 2'b01,
      PFD_DOWN = 2'b10
   } pfd_state_e;
endpackage

// ==== hw/pin_sync.sv ====
/*
 Two-flop synchroniser for a group of independent level inputs.
 Assumes each bit is a slow level; multi-bit values are not kept coherent.
*/
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk, // Destination clock
   input wire logic reset, // Synchronous reset, active high
   input wire logic [WIDTH-1:0] async_in, // Levels from outside the domain
   output logic [WIDTH-1:0] sync_out // Synchronised levels
);
   logic [WIDTH-1:0] meta_q;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always_ff @(posedge clk) begin
            if (reset) begin
               meta_q[i] <= RST_VAL[i];
               sync_out[i] <= RST_VAL[i];
            end else begin
               meta_q[i] <= async_in[i];
               sync_out[i] <= meta_q[i];
            end
         end
      end
   endgenerate
endmodule

// ==== hw/serial_shift_link.sv ====
/*
 Shift register of the three-wire load port, on the host's shift clock.
 Assumes the shift clock may stop between words; no reset reaches this domain.
*/
`timescale 1ns/1ps
`include "pll_consts.svh"
module serial_shift_link (
   input wire logic shift_clk, // Host shift clock
   input wire logic serial_data, // Serial data, valid at rising edge
   output logic [`SHIFT_W-1:0] shift_word_q // Last twenty bits, newest at top
);
   // New bit enters at the top, so the first bit sent ends lowest
   always_ff @(posedge shift_clk) begin
      shift_word_q <= {serial_data, shift_word_q[`SHIFT_W-1:1]};
   end
endmodule

// ==== hw/pll_core.sv ====
/*
 Digital core of a serial-programmed synthesizer: load latches, reference
 counter, dual-modulus divider chain, phase-frequency detector, pump drives,
 monitor and lock indicator.
 Assumes ref_clk is the reference oscillator; vco_input is a prescaled VCO
 level far slower than ref_clk; the host holds the shift register still
 while load_strobe is high. Main and bypass pump pins are a level and an enable each.
*/
`timescale 1ns/1ps
`include "pll_consts.svh"
module pll_core
   import pll_pkg::*;
(
   input wire logic ref_clk, // Reference oscillator clock
   input wire logic reset, // Synchronous reset, active high
   input wire logic shift_clk, // Host shift clock
   input wire logic serial_data, // Serial data pin
   input wire logic load_strobe, // Load strobe pin, pulled high when open
   input wire logic phase_polarity_select, // Polarity pin, pulled high when open
   input wire logic vco_input, // Prescaled VCO signal
   output logic ref_pump_drive, // External pump drive, reference side
   output logic vco_pump_drive, // External pump drive, VCO side
   output logic charge_pump_o, // Main pump level
   output logic charge_pump_oe, // Main pump drive enable
   output logic bypass_pump_o, // Bypass pump level
   output logic bypass_pump_oe, // Bypass pump drive enable
   output logic divider_monitor_out, // Test monitor
   output logic lock_indicator, // High when no phase error
   output logic ref_divided, // Divided reference
   output logic vco_divided // Divided VCO
);

   // ----------------------------------------
   // Pin synchronisers and the link
   // ----------------------------------------
   logic [`SHIFT_W-1:0] shift_word;
   logic [2:0] pins_s;
   logic strobe_s, fc_s, vco_s;
   logic vco_prev_q;
   logic vco_edge;

   serial_shift_link u_link (
      .shift_clk(shift_clk),
      .serial_data(serial_data),
      .shift_word_q(shift_word)
   );

   pin_sync #(.WIDTH(3), .RST_VAL(3'b011)) u_sync (
      .clk(ref_clk),
      .reset(reset),
      .async_in({vco_input, phase_polarity_select, load_strobe}),
      .sync_out(pins_s)
   );

   assign strobe_s = pins_s[0];
   assign fc_s = pins_s[1];
   assign vco_s = pins_s[2];

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         vco_prev_q <= 1'b0;
      end else begin
         vco_prev_q <= vco_s;
      end
   end

   assign vco_edge = vco_s & ~vco_prev_q;

   // ----------------------------------------
   // Load latches
   // ----------------------------------------
   logic armed_q;
   logic [`REF_LAT_W-1:0] ref_lat_q;
   logic [`DIV_LAT_W-1:0] div_lat_q;
   logic copy_en;

   // Copy only after a low strobe was seen, so reset never grabs a stale word
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         armed_q <= 1'b0;
      end else if (!strobe_s) begin
         armed_q <= 1'b1;
      end
   end

   assign copy_en = strobe_s & armed_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ref_lat_q <= `REF_LAT_RST;
      end else if (copy_en && shift_word[`CTRL_BIT]) begin
         ref_lat_q <= shift_word[`REF_LAT_MSB:`REF_LAT_LSB];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         div_lat_q <= `DIV_LAT_RST;
      end else if (copy_en && !shift_word[`CTRL_BIT]) begin
         div_lat_q <= shift_word[`DIV_LAT_W-1:0];
      end
   end

   // ----------------------------------------
   // Reference counter
   // ----------------------------------------
   logic [`RATIO_W-1:0] ref_cnt_q, ref_ratio_q;
   logic ref_div_q, ref_reload;

   assign ref_reload = (ref_cnt_q == '0);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ref_cnt_q <= '0;
         ref_ratio_q <= ref_lat_q[`RATIO_MSB:`RATIO_LSB];
      end else if (ref_reload) begin
         ref_cnt_q <= ref_lat_q[`RATIO_MSB:`RATIO_LSB] - 1'b1;
         ref_ratio_q <= ref_lat_q[`RATIO_MSB:`RATIO_LSB];
      end else begin
         ref_cnt_q <= ref_cnt_q - 1'b1;
      end
   end

   // Rises at reload, falls halfway through the period
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ref_div_q <= 1'b0;
      end else if (ref_reload) begin
         ref_div_q <= 1'b1;
      end else if (ref_cnt_q == (ref_ratio_q >> 1)) begin
         ref_div_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Prescaler, swallow and main counters
   // ----------------------------------------
   logic [`PRE_W-1:0] pre_cnt_q, pre_lo_new, pre_lo_q;
   logic [`SWALLOW_W-1:0] swallow_q, swallow_nx;
   logic [`MAIN_W-1:0] main_cnt_q, main_ratio_q;
   logic vco_div_q, pre_wrap, vco_reload;

   function automatic logic [`PRE_W-1:0] pre_modulus(input logic sel);
      pre_modulus = sel ? `PRE_LO_NARROW : `PRE_LO_WIDE;
   endfunction

   assign pre_lo_new = pre_modulus(ref_lat_q[`SEL_BIT]);
   assign pre_wrap = vco_edge && (pre_cnt_q == '0);
   assign vco_reload = pre_wrap && (main_cnt_q == `MAIN_ONE);
   assign swallow_nx = (swallow_q != '0) ? swallow_q - 1'b1 : swallow_q;

   // Prescaler counts P+1 edges while swallowing, P edges afterwards
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pre_cnt_q <= '0;
      end else if (vco_reload) begin
         pre_cnt_q <= (div_lat_q[`SWALLOW_MSB:0] != '0) ? pre_lo_new : pre_lo_new - 1'b1;
      end else if (pre_wrap) begin
         pre_cnt_q <= (swallow_nx != '0) ? pre_lo_q : pre_lo_q - 1'b1;
      end else if (vco_edge) begin
         pre_cnt_q <= pre_cnt_q - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pre_lo_q <= `PRE_LO_WIDE;
         swallow_q <= '0;
         main_cnt_q <= `MAIN_ONE;
         main_ratio_q <= div_lat_q[`MAIN_MSB:`MAIN_LSB];
      end else if (vco_reload) begin
         pre_lo_q <= pre_lo_new;
         swallow_q <= div_lat_q[`SWALLOW_MSB:0];
         main_cnt_q <= div_lat_q[`MAIN_MSB:`MAIN_LSB];
         main_ratio_q <= div_lat_q[`MAIN_MSB:`MAIN_LSB];
      end else if (pre_wrap) begin
         swallow_q <= swallow_nx;
         main_cnt_q <= main_cnt_q - 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         vco_div_q <= 1'b0;
      end else if (vco_reload) begin
         vco_div_q <= 1'b1;
      end else if (pre_wrap && (main_cnt_q == (main_ratio_q >> 1))) begin
         vco_div_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Phase-frequency detector
   // ----------------------------------------
   pfd_state_e pfd_q, pfd_d;

   // Leading edges only; a second lead edge saturates, bounding range to two pi
   always_comb begin
      pfd_d = pfd_q;
      unique case (pfd_q)
         PFD_IDLE: begin
            if (ref_reload && !vco_reload) begin
               pfd_d = PFD_UP;
            end else if (vco_reload && !ref_reload) begin
               pfd_d = PFD_DOWN;
            end
         end
         PFD_UP: begin
            if (vco_reload) begin
               pfd_d = PFD_IDLE;
            end
         end
         PFD_DOWN: begin
            if (ref_reload) begin
               pfd_d = PFD_IDLE;
            end
         end
         default: begin
            pfd_d = PFD_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pfd_q <= PFD_IDLE;
      end else begin
         pfd_q <= pfd_d;
      end
   end

   // ----------------------------------------
   // Output stage
   // ----------------------------------------
   logic up_d, down_d;
   logic ref_drv_q, vco_drv_q, cp_o_q, cp_oe_q, bp_oe_q, mon_q, lock_q;

   assign up_d = (pfd_d == PFD_UP);
   assign down_d = (pfd_d == PFD_DOWN);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ref_drv_q <= 1'b0;
         vco_drv_q <= 1'b1;
      end else if (fc_s) begin
         ref_drv_q <= down_d;
         vco_drv_q <= ~up_d;
      end else begin
         ref_drv_q <= up_d;
         vco_drv_q <= ~down_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cp_o_q <= 1'b0;
         cp_oe_q <= 1'b0;
         bp_oe_q <= 1'b0;
      end else begin
         cp_o_q <= up_d ? fc_s : ~fc_s;
         cp_oe_q <= up_d | down_d;
         bp_oe_q <= (up_d | down_d) & strobe_s;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mon_q <= 1'b0;
         lock_q <= 1'b1;
      end else begin
         mon_q <= fc_s ? ref_div_q : vco_div_q;
         lock_q <= ~(up_d | down_d);
      end
   end

   assign ref_pump_drive = ref_drv_q;
   assign vco_pump_drive = vco_drv_q;
   assign charge_pump_o = cp_o_q;
   assign charge_pump_oe = cp_oe_q;
   assign bypass_pump_o = cp_o_q;
   assign bypass_pump_oe = bp_oe_q;
   assign divider_monitor_out = mon_q;
   assign lock_indicator = lock_q;
   assign ref_divided = ref_div_q;
   assign vco_divided = vco_div_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   logic [`RATIO_W-1:0] ref_gap_q;
   logic ref_seen_q;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ref_gap_q <= '0;
         ref_seen_q <= 1'b0;
      end else if (ref_reload) begin
         ref_gap_q <= '0;
         ref_seen_q <= 1'b1;
      end else begin
         ref_gap_q <= ref_gap_q + 1'b1;
      end
   end

   a_ref_period: assert property (
      (ref_reload && ref_seen_q) |-> (ref_gap_q + 1'b1 == ref_ratio_q))
      else $error("reference period differs from active ratio");

   a_ref_latch_load: assert property (
      (copy_en && shift_word[`CTRL_BIT] && $stable(shift_word))
      |=> (ref_lat_q == $past(shift_word[`REF_LAT_MSB:`REF_LAT_LSB])))
      else $error("reference latch did not take shift word");

   a_div_latch_load: assert property (
      (copy_en && !shift_word[`CTRL_BIT] && $stable(shift_word))
      |=> (div_lat_q == $past(shift_word[`DIV_LAT_W-1:0])))
      else $error("divider latch did not take shift word");

   a_pfd_ref_lead: assert property (
      (pfd_q == PFD_IDLE && ref_reload && !vco_reload) |=> (pfd_q == PFD_UP))
      else $error("reference lead not seen by detector");

   a_fc_high_fast: assert property (
      (fc_s && pfd_d == PFD_DOWN) |=> (vco_pump_drive && ref_pump_drive))
      else $error("fast VCO drive wrong with polarity high");

   a_fc_high_slow: assert property (
      (fc_s && pfd_d == PFD_UP) |=> (!ref_pump_drive && !vco_pump_drive))
      else $error("slow VCO drive wrong with polarity high");

   a_fc_low_fast: assert property (
      (!fc_s && pfd_d == PFD_DOWN) |=> (!vco_pump_drive && !ref_pump_drive))
      else $error("fast VCO drive wrong with polarity low");

   a_locked_drives: assert property (
      (pfd_d == PFD_IDLE) |=> (vco_pump_drive && !ref_pump_drive))
      else $error("drives not quiet in lock");

   a_pump_release: assert property (
      (pfd_d == PFD_IDLE) |=> !charge_pump_oe)
      else $error("main pump driven while locked");

   a_pump_sense: assert property (
      (pfd_d == PFD_UP) |=> (charge_pump_oe && charge_pump_o == $past(fc_s)))
      else $error("main pump sense wrong");

   a_monitor_sel: assert property (
      ##1 (divider_monitor_out == ($past(fc_s) ? $past(ref_div_q) : $past(vco_div_q))))
      else $error("monitor shows wrong division");

   a_bypass_copy: assert property (
      $past(strobe_s) |-> (bypass_pump_oe == charge_pump_oe))
      else $error("bypass pump does not follow main pump");

   a_bypass_off: assert property (
      !strobe_s |=> !bypass_pump_oe)
      else $error("bypass pump driven with strobe low");

   a_lock_nor: assert property (
      lock_indicator == !(pfd_q == PFD_UP || pfd_q == PFD_DOWN))
      else $error("lock indicator not NOR of detector");

   c_ref_load: cover property (copy_en && shift_word[`CTRL_BIT]);
   c_div_load: cover property (copy_en && !shift_word[`CTRL_BIT]);
   c_pump_up: cover property (pfd_q == PFD_UP ##[1:50] pfd_q == PFD_IDLE);
   c_pump_down: cover property (pfd_q == PFD_DOWN ##[1:50] pfd_q == PFD_IDLE);
endmodule

// ==== tb/serial_host_model.sv ====
/*
 Host model of the three-wire load port: shifts whole words on its own clock.
 Assumes a 30 ns shift clock that stands still low between words.
*/
`timescale 1ns/1ps
module serial_host_model (
   output logic shift_clk, // Shift clock, low between words
   output logic serial_data, // Serial data
   output logic load_strobe // Load strobe, idles high as if open
);
   // ----------------------------------------
   // Word transfer
   // ----------------------------------------
   initial begin
      shift_clk = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b1;
   end

   task automatic shift_bit(input logic b);
      serial_data = b;
      #15 shift_clk = 1'b1;
      #15 shift_clk = 1'b0;
   endtask

   // Offset keeps every pin change away from the reference edges
   task automatic set_strobe(input logic v);
      #7 load_strobe = v;
   endtask

   // No pull on data: show the inverse once released
   task automatic close_frame();
      serial_data = ~serial_data;
      #30 load_strobe = 1'b1;
      #60;
   endtask

   task automatic send_ref(input logic [13:0] ratio, input logic sel);
      logic [15:0] w;
      w = {1'b1, ratio, sel};
      // Strobe must be seen low inside the core before the word moves
      #7 load_strobe = 1'b0;
      #60;
      for (int i = 0; i < 16; i++) begin
         shift_bit(w[i]);
      end
      close_frame();
   endtask

   task automatic send_div(input logic [10:0] main, input logic [7:0] swallow);
      logic [19:0] w;
      w = {1'b0, main, swallow};
      #7 load_strobe = 1'b0;
      #60;
      for (int i = 0; i < 20; i++) begin
         shift_bit(w[i]);
      end
      close_frame();
   endtask
endmodule

// ==== tb/serial_pll_divider_pfd_core_test.sv ====
/*
 Self-checking bench of the synthesizer core: periods, pump states, monitor.
 Assumes the host model drives the load port on its own 30 ns clock.
*/
`timescale 1ns/1ps
`include "pll_consts.svh"
module serial_pll_divider_pfd_core_test;
   import pll_pkg::*;
   logic ref_clk = 1'b0, reset = 1'b1, phase_polarity_select = 1'b1, vco_input = 1'b0;
   logic shift_clk, serial_data, load_strobe, ref_pump_drive, vco_pump_drive;
   logic charge_pump_o, charge_pump_oe, bypass_pump_o, bypass_pump_oe;
   logic divider_monitor_out, lock_indicator, ref_divided, vco_divided;
   int error_cnt = 0, tests_run = 0, cyc = 0, ref_t = 0, vco_t = 0, fc_age = 0, le_age = 0;
   logic ref_d1 = 1'b0, vco_d1 = 1'b0, fc_d1 = 1'b1, le_d1 = 1'b1, p, rr, vr;
   logic [31:0] seed = 32'hdb24_d5be;
   logic [31:0] ref_q[$], vco_q[$];
   logic [13:0] r;
   logic [7:0] swallow;
   pfd_state_e pfd = PFD_IDLE;

   always #5 ref_clk = ~ref_clk;

   // Prescaled VCO: one rise every four reference cycles
   always begin
      repeat (2) @(posedge ref_clk);
      vco_input <= ~vco_input;
   end

   serial_host_model host (.shift_clk(shift_clk), .serial_data(serial_data),
      .load_strobe(load_strobe));

   pll_core DUT (.ref_clk(ref_clk), .reset(reset), .shift_clk(shift_clk),
      .serial_data(serial_data), .load_strobe(load_strobe),
      .phase_polarity_select(phase_polarity_select), .vco_input(vco_input),
      .ref_pump_drive(ref_pump_drive), .vco_pump_drive(vco_pump_drive),
      .charge_pump_o(charge_pump_o), .charge_pump_oe(charge_pump_oe),
      .bypass_pump_o(bypass_pump_o), .bypass_pump_oe(bypass_pump_oe),
      .divider_monitor_out(divider_monitor_out), .lock_indicator(lock_indicator),
      .ref_divided(ref_divided), .vco_divided(vco_divided));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Note the period of the first full cycle begun after a six-cycle wait, on the new ratio
   task automatic measure(input logic on_vco, input logic [31:0] n);
      repeat (6) @(posedge ref_clk);
      @(posedge (on_vco ? vco_divided : ref_divided));
      repeat (2) @(posedge ref_clk);
      if (on_vco) begin
         vco_q.push_back(n);
      end else begin
         ref_q.push_back(n);
      end
      @(posedge (on_vco ? vco_divided : ref_divided));
      repeat (2) @(posedge ref_clk);
   endtask

   // ----------------------------------------
   // Output watcher with detector model
   // ----------------------------------------
   always @(posedge ref_clk) begin
      cyc++;
      if (reset) begin
         pfd = PFD_IDLE;
      end else begin
         rr = (ref_divided === 1'b1 && ref_d1 === 1'b0);
         vr = (vco_divided === 1'b1 && vco_d1 === 1'b0);
         // Coinciding leading edges cancel in every state
         if (rr && vr) begin
            pfd = PFD_IDLE;
         end else if (rr) begin
            pfd = (pfd == PFD_DOWN) ? PFD_IDLE : PFD_UP;
         end else if (vr) begin
            pfd = (pfd == PFD_UP) ? PFD_IDLE : PFD_DOWN;
         end
         if (rr) begin
            if (ref_q.size() > 0) check("ref_period", cyc - ref_t, ref_q.pop_front());
            ref_t = cyc;
         end
         if (vr) begin
            if (vco_q.size() > 0) check("vco_period", cyc - vco_t, vco_q.pop_front());
            vco_t = cyc;
         end
         check("lock_indicator", lock_indicator, pfd == PFD_IDLE);
         check("charge_pump_oe", charge_pump_oe, pfd != PFD_IDLE);
         p = fc_d1 ^ (pfd == PFD_UP);
         if (fc_age > 4) begin
            check("monitor", divider_monitor_out, fc_d1 ? ref_d1 : vco_d1);
            if (pfd == PFD_IDLE) begin
               check("idle_pumps", {vco_pump_drive, ref_pump_drive}, 2'b10);
            end else begin
               check("pumps", {ref_pump_drive, vco_pump_drive, charge_pump_o}, {p, p, ~p});
            end
         end
         if (le_age > 4) begin
            check("bypass_oe", bypass_pump_oe, (pfd != PFD_IDLE) && le_d1);
            if (fc_age > 4 && pfd != PFD_IDLE && le_d1) check("bypass_lvl", bypass_pump_o, !p);
         end
      end
      fc_age = (phase_polarity_select === fc_d1) ? fc_age + 1 : 0;
      le_age = (load_strobe === le_d1) ? le_age + 1 : 0;
      fc_d1 = phase_polarity_select;
      le_d1 = load_strobe;
      ref_d1 = ref_divided;
      vco_d1 = vco_divided;
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      fork
         begin
            repeat (8) @(posedge ref_clk);
            check("reset_state", {lock_indicator, vco_pump_drive, charge_pump_oe}, 3'b110);
            reset <= 1'b0;
            for (int i = 0; i < 3; i++) begin
               seed = lfsr(seed);
               r = (i == 0) ? 14'h0008 : 14'h0008 + {9'h000, seed[4:0]};
               @(posedge ref_clk);
               phase_polarity_select <= seed[8];
               host.send_ref(r, 1'b1);
               measure(1'b0, {18'h0_0000, r});
            end
            seed = lfsr(seed);
            swallow = {4'h0, seed[3:0]};
            host.send_div(11'h010, swallow);
            host.send_ref(14'h3fff, 1'b1);
            measure(1'b1, (`PRE_LO_NARROW * 11'h010 + swallow) * 3'h4);
            @(posedge ref_clk);
            phase_polarity_select <= ~phase_polarity_select;
            host.set_strobe(1'b0);
            repeat (3000) @(posedge ref_clk);
            host.send_ref(14'h0008, 1'b0);
            measure(1'b0, 32'h0000_0008);
            measure(1'b1, (`PRE_LO_WIDE * 11'h010 + swallow) * 3'h4);
         end
         begin
            // Longest path is well under this ceiling
            wait (cyc >= 90000);
            error_cnt++;
         end
      join_any
      summarize();
   end
endmodule
